// ### hw/adcc_core.sv
// Purpose: successive-approximation converter control and register file
// Assumes: comparator answer valid from analog core on each resolve tick
// Notes: sleep pulse mimics entry; wake pulse restores reset values
`timescale 1ns/100ps
module adcc_core import adcc_pkg::*; (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       clkEn,
    // register port
    input  wire logic [1:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    // power events
    input  wire logic       sleepEnter,
    input  wire logic       wakeUp,
    // analog core
    input  wire logic       oscTick,
    input  wire logic       cmpHigh,
    input  wire logic       cmp1OutEn,
    output logic      [1:0] muxChannel,
    output logic      [7:0] dacCode,
    output logic            sampleOn,
    output logic            analogPowered,
    // pins
    output logic      [2:0] pinDigitalEn,
    output logic            pin2CmpOut
);
    logic [1:0]  pinSel_q;
    logic [1:0]  clkSel_q;
    logic [1:0]  chSel_q;
    logic        go_q;
    logic        power_q;
    logic [1:0]  runClk_q;
    logic [7:0]  result_q;
    logic        marker_q;
    logic [7:0]  trial_q;
    logic [3:0]  tickCnt_q;
    adcc_state_t state_q;
    logic        tick;
    logic        startNow;
    logic        wrCtl;
    logic        done;
    logic [7:0]  ctlWord;

    assign wrCtl    = regWrite && regAddr == ADCC_ADDR_CONTROL;
    assign startNow = wrCtl && regWrData[ADCC_POS_GO] && regWrData[ADCC_POS_POWER]
                      && !go_q && !sleepEnter && !wakeUp;
    // ninth resolve tick: the marker leaves after bit 0 was stuffed
    assign done     = state_q == ADCC_RESOLVE && tick && trial_q == 8'h00;
    assign ctlWord  = {pinSel_q, clkSel_q, chSel_q, go_q, power_q};

    // clock source latched at start so mid-run writes wait
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            runClk_q <= ADCC_FIELD_ONES;
        end else if (clkEn && startNow) begin
            runClk_q <= regWrData[5:4];
        end
    end

    adcc_tick_gen u_tick (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clkEn   (clkEn),
        .restart (startNow),
        .clkSel  (runClk_q),
        .oscTick (oscTick),
        .tick    (tick)
    );

    // control register fields
    always_ff @(posedge ref_clk) begin
        if (srst || (clkEn && wakeUp)) begin
            pinSel_q <= ADCC_CONTROL_RESET[7:6];
            clkSel_q <= ADCC_CONTROL_RESET[5:4];
            chSel_q  <= ADCC_CONTROL_RESET[3:2];
            power_q  <= 1'b0;
        end else if (clkEn) begin
            if (sleepEnter) begin
                clkSel_q <= ADCC_FIELD_ONES;
                chSel_q  <= ADCC_FIELD_ONES;
                power_q  <= 1'b0;
            end else if (wrCtl) begin
                pinSel_q <= regWrData[7:6];
                clkSel_q <= regWrData[5:4];
                chSel_q  <= regWrData[3:2];
                power_q  <= regWrData[ADCC_POS_POWER];
            end
        end
    end

    // go flag: software start/abort, hardware clear on completion
    always_ff @(posedge ref_clk) begin
        if (srst || (clkEn && wakeUp)) begin
            go_q <= 1'b0;
        end else if (clkEn) begin
            if (sleepEnter) begin
                go_q <= 1'b0;
            end else if (startNow) begin
                go_q <= 1'b1;
            end else if (wrCtl && !regWrData[ADCC_POS_GO]) begin
                go_q <= 1'b0;
            end else if (done) begin
                go_q <= 1'b0;
            end
        end
    end

    // channel to mux only between conversions
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            muxChannel <= ADCC_FIELD_ONES;
        end else if (clkEn && state_q == ADCC_IDLE) begin
            // a starting write must sample the channel it carries
            muxChannel <= startNow ? regWrData[3:2] : chSel_q;
        end
    end

    // sequencer: 4 sample ticks then 9 resolve ticks, 13 total
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q   <= ADCC_IDLE;
            tickCnt_q <= 4'h0;
            trial_q   <= 8'h00;
            marker_q  <= 1'b0;
            result_q  <= 8'h00;
        end else if (clkEn) begin
            case (state_q)
                ADCC_IDLE: begin
                    if (startNow) begin
                        state_q   <= ADCC_SAMPLE;
                        tickCnt_q <= 4'h0;
                    end
                end
                ADCC_SAMPLE: begin
                    if (!go_q) begin
                        state_q <= ADCC_IDLE;
                    end else if (tick) begin
                        tickCnt_q <= tickCnt_q + 4'h1;
                        if (tickCnt_q == ADCC_SAMPLE_TICKS - 4'h1) begin
                            state_q  <= ADCC_RESOLVE;
                            result_q <= 8'h00;
                            marker_q <= 1'b1;
                            trial_q  <= 8'h80;
                        end
                    end
                end
                ADCC_RESOLVE: begin
                    if (!go_q) begin
                        state_q <= ADCC_IDLE;
                    end else if (tick) begin
                        tickCnt_q <= tickCnt_q + 4'h1;
                        if (trial_q == 8'h00) begin
                            state_q  <= ADCC_IDLE;
                            marker_q <= 1'b0;
                        end else begin
                            result_q <= result_q | (cmpHigh ? trial_q : 8'h00);
                        end
                        trial_q <= trial_q >> 1;
                    end
                end
                default: state_q <= ADCC_IDLE;
            endcase
        end
    end

    // analog core drive and pin config
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dacCode       <= 8'h00;
            sampleOn      <= 1'b0;
            analogPowered <= 1'b0;
            pinDigitalEn  <= 3'h0;
            pin2CmpOut    <= 1'b0;
        end else if (clkEn) begin
            dacCode       <= result_q | trial_q;
            sampleOn      <= state_q == ADCC_SAMPLE;
            analogPowered <= power_q;
            // independent of power bit
            pinDigitalEn[0] <= pinSel_q < 2'h2;
            pinDigitalEn[1] <= pinSel_q != 2'h3;
            pinDigitalEn[2] <= pinSel_q == 2'h0 && !cmp1OutEn;
            pin2CmpOut      <= cmp1OutEn;
        end
    end

    // read port, data one cycle after strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else if (clkEn) begin
            regRdData <= 8'h00;
            if (regRead) begin
                case (regAddr)
                    ADCC_ADDR_CONTROL: regRdData <= ctlWord;
                    ADCC_ADDR_RESULT:  regRdData <= result_q;
                    ADCC_ADDR_STATUS:  regRdData <= {5'h00, marker_q, state_q};
                    default:           regRdData <= 8'h00;
                endcase
            end
        end
    end

    // assertions
    sequence s_start;
        startNow && clkEn;
    endsequence

    property p_unpowered_start;
        @(posedge ref_clk) disable iff (srst)
        (clkEn && wrCtl && !power_q && !regWrData[ADCC_POS_POWER] && !go_q) |=> !go_q;
    endproperty
    a_unpowered_start: assert property (p_unpowered_start) else $error("start while off");

    property p_start_sets;
        @(posedge ref_clk) disable iff (srst) s_start |=> go_q && state_q == ADCC_SAMPLE;
    endproperty
    a_start_sets: assert property (p_start_sets) else $error("start not taken");

    property p_sleep;
        @(posedge ref_clk) disable iff (srst)
        (clkEn && sleepEnter && !wakeUp) |=> !go_q && !power_q && clkSel_q == 2'h3
            && chSel_q == 2'h3 && pinSel_q == $past(pinSel_q);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep effect wrong");

    property p_done_clears;
        @(posedge ref_clk) disable iff (srst) (clkEn && done && !wrCtl && !sleepEnter
            && !wakeUp) |=> !go_q && state_q == ADCC_IDLE;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("done not cleared");

    property p_mux_hold;
        @(posedge ref_clk) disable iff (srst)
        (state_q != ADCC_IDLE) |=> muxChannel == $past(muxChannel);
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("mux changed mid run");

    property p_abort;
        @(posedge ref_clk) disable iff (srst)
        (clkEn && state_q == ADCC_RESOLVE && !go_q) |=> state_q == ADCC_IDLE
            && result_q == $past(result_q);
    endproperty
    a_abort: assert property (p_abort) else $error("abort lost bits");

    property p_thirteen;
        @(posedge ref_clk) disable iff (srst)
        done |-> tickCnt_q == ADCC_TOTAL_TICKS - 4'h1;
    endproperty
    a_thirteen: assert property (p_thirteen) else $error("period count wrong");

    property p_clk_latch;
        @(posedge ref_clk) disable iff (srst)
        (state_q != ADCC_IDLE && !startNow) |=> runClk_q == $past(runClk_q);
    endproperty
    a_clk_latch: assert property (p_clk_latch) else $error("clock changed mid run");
endmodule

// ### hw/adcc_pkg.sv
// Purpose: constants for the converter control block
// Assumes: one clock, plain register port, 8-bit control register
// Notes: clock select 11 counts internal-oscillator ticks, divided by 4
package adcc_pkg;
    localparam logic [1:0] ADCC_ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADCC_ADDR_RESULT  = 2'h1;
    localparam logic [1:0] ADCC_ADDR_STATUS  = 2'h2;
    localparam int ADCC_POS_PINSEL = 6;
    localparam int ADCC_POS_CLKSEL = 4;
    localparam int ADCC_POS_CHSEL  = 2;
    localparam int ADCC_POS_GO     = 1;
    localparam int ADCC_POS_POWER  = 0;
    localparam logic [7:0] ADCC_CONTROL_RESET = 8'hFC;
    localparam logic [1:0] ADCC_FIELD_ONES    = 2'h3;
    localparam logic [3:0] ADCC_SAMPLE_TICKS  = 4'h4;
    localparam logic [3:0] ADCC_TOTAL_TICKS   = 4'hD;
    localparam logic [4:0] ADCC_DIV_16 = 5'h10;
    localparam logic [4:0] ADCC_DIV_8  = 5'h08;
    localparam logic [4:0] ADCC_DIV_4  = 5'h04;
    typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_RESOLVE} adcc_state_t;
endpackage

// ### hw/adcc_tick_gen.sv
// Purpose: conversion-clock tick generator
// Assumes: oscTick is a single-cycle internal oscillator pulse, same clock
// Notes: count restarts on restart pulse
`timescale 1ns/100ps
module adcc_tick_gen import adcc_pkg::*; (
    // clock
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       clkEn,
    // control
    input  wire logic       restart,
    input  wire logic [1:0] clkSel,
    input  wire logic       oscTick,
    // tick
    output logic            tick
);
    logic [4:0] cnt_q;
    logic [4:0] divisor;
    logic       advance;

    always_comb begin
        advance = 1'b1;
        case (clkSel)
            2'h0:    divisor = ADCC_DIV_16;
            2'h1:    divisor = ADCC_DIV_8;
            2'h2:    divisor = ADCC_DIV_4;
            default: begin
                divisor = ADCC_DIV_4;
                advance = oscTick;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_q <= 5'h00;
            tick  <= 1'b0;
        end else if (clkEn) begin
            if (restart) begin
                cnt_q <= 5'h00;
                tick  <= 1'b0;
            end else if (advance) begin
                tick  <= (cnt_q == divisor - 5'h01);
                cnt_q <= (cnt_q == divisor - 5'h01) ? 5'h00 : cnt_q + 5'h01;
            end else begin
                tick <= 1'b0;
            end
        end
    end
endmodule

// ### verification/adcc_analog_model.sv
// Purpose: analog sampling core and internal oscillator stand-in
// Assumes: held input level, ideal comparator, oscillator pulse every OSC_PERIOD cycles
// Notes: the comparator answers at once, which is as fast as the real core can be
`timescale 1ns/100ps
module adcc_analog_model #(
    parameter int OSC_PERIOD = 3
) (
    // clock
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // analog side
    input  wire logic [7:0] analogLevel,
    input  wire logic [7:0] dacCode,
    output logic            cmpHigh,
    output logic            oscTick
);
    int oscCnt_q;

    // the trial code is judged against the held input level
    assign cmpHigh = (analogLevel >= dacCode);

    // oscillator ticks derive from the one instruction clock
    always_ff @(posedge ref_clk) begin
        if (srst || oscCnt_q == OSC_PERIOD - 1) begin
            oscCnt_q <= 0;
        end else begin
            oscCnt_q <= oscCnt_q + 1;
        end
        oscTick <= !srst && (oscCnt_q == OSC_PERIOD - 1);
    end
endmodule

// ### verification/adc_conversion_control_tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: register port read data stands one cycle after the strobe
// Notes: conversion times are checked within a small window for poll granularity
`timescale 1ns/100ps
module adc_conversion_control_tb import adcc_pkg::*;;
    localparam int OSC_P = 3;
    logic       ref_clk = 1'b0;
    logic       srst = 1'b1;
    logic       clkEn = 1'b1;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic [7:0] regRdData;
    logic       sleepEnter = 1'b0;
    logic       wakeUp = 1'b0;
    logic       cmp1OutEn = 1'b0;
    logic       oscTick;
    logic       cmpHigh;
    logic [1:0] muxChannel;
    logic [7:0] dacCode;
    logic       sampleOn;
    logic       analogPowered;
    logic [2:0] pinDigitalEn;
    logic       pin2CmpOut;
    logic [7:0] analogLevel = 8'hA5;
    logic [7:0] rdv;
    int         errors = 0;
    int         comparisons = 0;
    int         cyc;

    always #2 ref_clk = ~ref_clk;

    adcc_core dut (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .sleepEnter(sleepEnter), .wakeUp(wakeUp),
        .oscTick(oscTick), .cmpHigh(cmpHigh), .cmp1OutEn(cmp1OutEn),
        .muxChannel(muxChannel), .dacCode(dacCode), .sampleOn(sampleOn),
        .analogPowered(analogPowered), .pinDigitalEn(pinDigitalEn),
        .pin2CmpOut(pin2CmpOut));

    adcc_analog_model #(.OSC_PERIOD(OSC_P)) analog (.ref_clk(ref_clk), .srst(srst),
        .analogLevel(analogLevel), .dacCode(dacCode), .cmpHigh(cmpHigh),
        .oscTick(oscTick));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [1:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rdv = regRdData;
        @(posedge ref_clk);
    endtask

    // polls the start flag; two cycles per poll
    task automatic wait_done();
        cyc = 0;
        do begin
            rd(ADCC_ADDR_CONTROL);
            cyc += 2;
        end while (rdv[ADCC_POS_GO] === 1'b1 && cyc < 4000);
        if (cyc >= 4000) errors++;
    endtask

    task automatic chk_time(input int div, input int extra);
        chk("convTime", 8'h01, 8'((cyc + extra >= 13 * div - 6) && (cyc + extra <= 13 * div + 6)));
    endtask

    task automatic t_reset();
        rd(ADCC_ADDR_CONTROL);
        chk("ctrlReset", ADCC_CONTROL_RESET, rdv);
        chk("muxReset", 8'h03, 8'(muxChannel));
        chk("pinsReset", 8'h00, 8'(pinDigitalEn));
    endtask

    task automatic t_convert(input logic [1:0] cs, input int div);
        wr(ADCC_ADDR_CONTROL, {2'h3, cs, 2'h0, 2'h3});
        wait_done();
        chk_time(div, 0);
        rd(ADCC_ADDR_RESULT);
        chk("result", analogLevel, rdv);
    endtask

    task automatic t_deferred();
        wr(ADCC_ADDR_CONTROL, 8'hE3);
        wr(ADCC_ADDR_CONTROL, 8'hC7);
        chk("muxHeld", 8'h00, 8'(muxChannel));
        wait_done();
        chk_time(4, 2);
        chk("muxAfter", 8'h01, 8'(muxChannel));
    endtask

    task automatic t_abort();
        wr(ADCC_ADDR_CONTROL, 8'hC3);
        repeat (110) @(posedge ref_clk);
        wr(ADCC_ADDR_CONTROL, 8'hC1);
        rd(ADCC_ADDR_STATUS);
        chk("stateAbort", 8'h00, 8'(rdv[1:0]));
        chk("markerAbort", 8'h01, 8'(rdv[2]));
        rd(ADCC_ADDR_CONTROL);
        chk("ctrlAbort", 8'hC1, rdv);
    endtask

    task automatic t_nopower();
        wr(ADCC_ADDR_CONTROL, 8'hFE);
        rd(ADCC_ADDR_CONTROL);
        chk("goNoPower", 8'hFC, rdv);
        chk("powerOff", 8'h00, 8'(analogPowered));
    endtask

    task automatic t_sleep();
        wr(ADCC_ADDR_CONTROL, 8'hA3);
        repeat (20) @(posedge ref_clk);
        sleepEnter <= 1'b1;
        @(posedge ref_clk);
        sleepEnter <= 1'b0;
        @(posedge ref_clk);
        rd(ADCC_ADDR_CONTROL);
        chk("ctrlSleep", 8'hBC, rdv);
        chk("powerSleep", 8'h00, 8'(analogPowered));
        wakeUp <= 1'b1;
        @(posedge ref_clk);
        wakeUp <= 1'b0;
        @(posedge ref_clk);
        rd(ADCC_ADDR_CONTROL);
        chk("ctrlWake", ADCC_CONTROL_RESET, rdv);
    endtask

    task automatic t_pins();
        logic [2:0] expPins [4] = '{3'h7, 3'h3, 3'h2, 3'h0};
        for (int i = 0; i < 4; i++) begin
            wr(ADCC_ADDR_CONTROL, {2'(i), 6'h3C});
            // drivers follow the field one cycle late
            @(posedge ref_clk);
            chk("pinDrivers", 8'(expPins[i]), 8'(pinDigitalEn));
        end
        cmp1OutEn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("cmpOverride", 8'h01, 8'(pin2CmpOut));
        cmp1OutEn <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_convert(2'h0, 16);
        t_convert(2'h1, 8);
        t_convert(2'h2, 4);
        t_convert(2'h3, 4 * OSC_P);
        t_deferred();
        t_abort();
        t_nopower();
        t_sleep();
        t_pins();
        give_verdict();
    end

    // whole run needs well under 3000 cycles
    initial begin
        #40000;
        errors++;
        give_verdict();
    end
endmodule
